// ===== rtl/bchr_map.svh
`ifndef BCHR_MAP_SVH
`define BCHR_MAP_SVH
// register word offsets (byte addresses)
`define BCHR_OFS_CMD_STAT 8'h04
`define BCHR_OFS_REV_CLASS 8'h08
`define BCHR_OFS_CACHE_HDR 8'h0c
`define BCHR_OFS_BUS 8'h18
// command half-word control bits
`define BCHR_CMD_PERR_BIT 6
`define BCHR_CMD_SERR_BIT 8
// status bits, word positions
`define BCHR_ST_INTX_BIT 19
`define BCHR_ST_CAPL_BIT 20
`define BCHR_ST_MDPE_BIT 24
`define BCHR_ST_STA_BIT 27
`define BCHR_ST_RTA_BIT 28
`define BCHR_ST_RMA_BIT 29
`define BCHR_ST_SSE_BIT 30
`define BCHR_ST_DPE_BIT 31
// fixed read values
`define BCHR_CAPL_VAL 1'b1
`define BCHR_INTX_VAL 1'b0
`define BCHR_PROG_IF 8'h00
`define BCHR_SUB_CLASS 8'h04
`define BCHR_BASE_CLASS 8'h06
`define BCHR_HDR_TYPE 8'h01
`define BCHR_LAT_TIMER 8'h00
// reset values
`define BCHR_RST_BYTE 8'h00
`define BCHR_RST_WORD 32'h0000_0000
`endif

// ===== rtl/bchr_pkg.sv
`default_nettype none
package bchr_pkg;
  // event strobes from the port's transaction logic
  typedef struct packed {
    logic parity;
    logic ca_sent;
    logic ca_rcvd;
    logic ur_rcvd;
    logic err_msg;
    logic poison;
  } bchr_evt_t;
  // sticky status flags
  typedef struct packed {
    logic dpe;
    logic sse;
    logic rma;
    logic rta;
    logic sta;
    logic mdpe;
  } bchr_flags_t;
  // bus number triple
  typedef struct packed {
    logic [7:0] highest;
    logic [7:0] downstream;
    logic [7:0] upstream;
  } bchr_bus_t;
  // whole block state
  typedef struct packed {
    logic [31:0] rdata;
    logic perr_en;
    logic serr_en;
    logic [7:0] cache_line;
    bchr_bus_t bus;
    bchr_flags_t flags;
  } bchr_state_t;
endpackage : bchr_pkg
`default_nettype wire

// ===== rtl/bchr_regs.sv
`include "bchr_map.svh"
`default_nettype none

// What this block does
// - interrupt pending bit always reads zero
// - capabilities list bit reads one
// - legacy speed and timing bits read zero
// - parity error on primary sets data-parity flag
// - no data-parity flag while response disabled
// - completer abort sent sets signaled abort
// - completer abort received sets target abort
// - unsupported request received sets master abort
// - error message with enable sets system error
// - poisoned packet received sets detected parity
// - class code reads 06h 04h 00h
// - cache line byte writable, no effect
// - both latency timers read zero
// - header type reads 01h
// - upstream bus number writable, resets zero
// - downstream bus number writable, resets zero
// - highest bus number writable, resets zero
// - revision identifier fixed, read only
// - system error enable gates error reporting
// - parity response enable steers parity action
module bchr_regs
  import bchr_pkg::*;
#(
  // revision code, value arbitrary
  parameter logic [7:0] REV_ID = 8'h3c
) (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // transaction events
  input wire bchr_evt_t evt,
  // control out to port logic
  output logic perr_resp_en,
  output logic serr_en,
  output bchr_bus_t bus_num,
  output bchr_flags_t status_flags
);

  // registered and next state
  bchr_state_t st_q;
  bchr_state_t st_d;

  // decoded writes
  logic wr_cmd;
  logic wr_cache;
  logic wr_bus;
  // read word before the flop
  logic [31:0] rd_word;
  // status half-word view
  logic [15:0] stat_hw;
  // flag set terms
  bchr_flags_t set_v;
  // flag clear terms
  bchr_flags_t clr_v;

  // write address decode
  assign wr_cmd = reg_wr && (reg_addr == `BCHR_OFS_CMD_STAT);
  assign wr_cache = reg_wr && (reg_addr == `BCHR_OFS_CACHE_HDR);
  assign wr_bus = reg_wr && (reg_addr == `BCHR_OFS_BUS);

  // status half-word assembly
  always_comb begin
    stat_hw = 16'h0000; // reserved stay zero
    stat_hw[`BCHR_ST_INTX_BIT-16] = `BCHR_INTX_VAL;
    stat_hw[`BCHR_ST_CAPL_BIT-16] = `BCHR_CAPL_VAL;
    // 66 MHz, fast b2b, select timing left zero
    stat_hw[`BCHR_ST_MDPE_BIT-16] = st_q.flags.mdpe;
    stat_hw[`BCHR_ST_STA_BIT-16] = st_q.flags.sta;
    stat_hw[`BCHR_ST_RTA_BIT-16] = st_q.flags.rta;
    stat_hw[`BCHR_ST_RMA_BIT-16] = st_q.flags.rma;
    stat_hw[`BCHR_ST_SSE_BIT-16] = st_q.flags.sse;
    stat_hw[`BCHR_ST_DPE_BIT-16] = st_q.flags.dpe;
  end

  // read data mux
  always_comb begin
    rd_word = `BCHR_RST_WORD;
    unique case (reg_addr)
      `BCHR_OFS_CMD_STAT: begin
        // command bits we hold, the rest zero
        rd_word[`BCHR_CMD_PERR_BIT] = st_q.perr_en;
        rd_word[`BCHR_CMD_SERR_BIT] = st_q.serr_en;
        rd_word[31:16] = stat_hw;
      end
      `BCHR_OFS_REV_CLASS: begin
        // revision and class code
        rd_word = {`BCHR_BASE_CLASS, `BCHR_SUB_CLASS,
                   `BCHR_PROG_IF, REV_ID};
      end
      `BCHR_OFS_CACHE_HDR: begin
        // cache line, latency, header type
        rd_word = {8'h00, `BCHR_HDR_TYPE,
                   `BCHR_LAT_TIMER, st_q.cache_line};
      end
      `BCHR_OFS_BUS: begin
        // bus numbers, latency timer on top
        rd_word = {`BCHR_LAT_TIMER, st_q.bus};
      end
      default: begin
        // unmapped reads as zero
        rd_word = `BCHR_RST_WORD;
      end
    endcase
  end

  // event set terms
  always_comb begin
    set_v = '0;
    // parity only with response enabled
    set_v.mdpe = evt.parity && st_q.perr_en;
    set_v.sta = evt.ca_sent;
    set_v.rta = evt.ca_rcvd;
    set_v.rma = evt.ur_rcvd;
    set_v.sse = evt.err_msg && st_q.serr_en;
    set_v.dpe = evt.poison;
  end

  // software clear terms, clearable flags only
  always_comb begin
    clr_v = '0;
    if (wr_cmd) begin
      clr_v.mdpe = reg_wdata[`BCHR_ST_MDPE_BIT];
      clr_v.sse = reg_wdata[`BCHR_ST_SSE_BIT];
      clr_v.dpe = reg_wdata[`BCHR_ST_DPE_BIT];
    end
  end

  // next state
  always_comb begin
    st_d = st_q;
    // data stands only after a read
    st_d.rdata = reg_rd ? rd_word : `BCHR_RST_WORD;
    // control bits of the command half
    if (wr_cmd) begin
      st_d.perr_en = reg_wdata[`BCHR_CMD_PERR_BIT];
      st_d.serr_en = reg_wdata[`BCHR_CMD_SERR_BIT];
    end
    // cache line byte, storage only
    if (wr_cache) begin
      st_d.cache_line = reg_wdata[7:0];
    end
    // bus numbers, top byte read only
    if (wr_bus) begin
      st_d.bus = reg_wdata[23:0];
    end
    // set wins over clear
    st_d.flags = (st_q.flags & ~clr_v) | set_v;
  end

  // state register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0; // all fields reset to zero
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  // outputs straight from flops
  assign reg_rdata = st_q.rdata;
  assign perr_resp_en = st_q.perr_en;
  assign serr_en = st_q.serr_en;
  assign bus_num = st_q.bus;
  assign status_flags = st_q.flags;

  // checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  // status read view
  sequence s_rd_stat;
    clk_en && reg_rd && reg_addr == `BCHR_OFS_CMD_STAT;
  endsequence

  a_intx_zero: assert property (
    s_rd_stat |=> !reg_rdata[`BCHR_ST_INTX_BIT])
    else $error("interrupt pending bit read one");

  a_capl_one: assert property (
    s_rd_stat |=> reg_rdata[`BCHR_ST_CAPL_BIT])
    else $error("capabilities bit read zero");

  a_legacy_zero: assert property (
    s_rd_stat |=> reg_rdata[26:25] == 2'b00
      && !reg_rdata[23] && !reg_rdata[21])
    else $error("legacy status bits not zero");

  a_rsvd_zero: assert property (
    s_rd_stat |=> reg_rdata[18:16] == 3'b000 && !reg_rdata[22])
    else $error("reserved status bits not zero");

  a_mdpe_set: assert property (
    clk_en && evt.parity && perr_resp_en |=> status_flags.mdpe)
    else $error("parity flag not set");

  a_mdpe_gated: assert property (
    $rose(status_flags.mdpe) |-> $past(perr_resp_en && evt.parity))
    else $error("parity flag set while disabled");

  a_aborts_set: assert property (
    clk_en && evt.ca_sent |=> status_flags.sta [*2])
    else $error("signaled abort lost");

  a_rta_set: assert property (
    clk_en && evt.ca_rcvd |=> status_flags.rta)
    else $error("target abort not set");

  a_rma_set: assert property (
    clk_en && evt.ur_rcvd |=> status_flags.rma)
    else $error("master abort not set");

  a_sse_gate: assert property (
    $rose(status_flags.sse) |-> $past(serr_en && evt.err_msg))
    else $error("system error set without cause");

  a_dpe_set: assert property (
    clk_en && evt.poison |=> status_flags.dpe)
    else $error("detected parity not set");

  a_class_val: assert property (
    clk_en && reg_rd && reg_addr == `BCHR_OFS_REV_CLASS
      |=> reg_rdata == {`BCHR_BASE_CLASS, `BCHR_SUB_CLASS,
                        `BCHR_PROG_IF, REV_ID})
    else $error("class or revision word wrong");

  a_cache_hdr: assert property (
    clk_en && reg_wr && reg_addr == `BCHR_OFS_CACHE_HDR
      ##1 clk_en && reg_rd && reg_addr == `BCHR_OFS_CACHE_HDR
      |=> reg_rdata == {16'h0001, 8'h00, $past(reg_wdata[7:0], 2)})
    else $error("cache line or header word wrong");

  a_bus_write: assert property (
    clk_en && reg_wr && reg_addr == `BCHR_OFS_BUS
      |=> bus_num == $past(reg_wdata[23:0]))
    else $error("bus numbers not written");

  a_w1c_clear: assert property (
    clk_en && reg_wr && reg_addr == `BCHR_OFS_CMD_STAT
      && reg_wdata[`BCHR_ST_DPE_BIT] && !evt.poison
      |=> !status_flags.dpe)
    else $error("detected parity not cleared");

  // abort flags are read only: write-one must not clear them
  a_ro_flags_keep: assert property (
    clk_en && reg_wr && reg_addr == `BCHR_OFS_CMD_STAT
      && reg_wdata[`BCHR_ST_RTA_BIT] && status_flags.rta |=> status_flags.rta)
    else $error("target abort cleared by write");

  a_sta_keep: assert property (
    clk_en && reg_wr && reg_addr == `BCHR_OFS_CMD_STAT
      && reg_wdata[`BCHR_ST_STA_BIT] && status_flags.sta |=> status_flags.sta)
    else $error("signaled abort cleared by write");

  a_rma_keep: assert property (
    clk_en && reg_wr && reg_addr == `BCHR_OFS_CMD_STAT
      && reg_wdata[`BCHR_ST_RMA_BIT] && status_flags.rma |=> status_flags.rma)
    else $error("master abort cleared by write");

  // write-one clears the other clearable flags
  a_mdpe_clear: assert property (
    clk_en && reg_wr && reg_addr == `BCHR_OFS_CMD_STAT
      && reg_wdata[`BCHR_ST_MDPE_BIT] && !(evt.parity && perr_resp_en)
      |=> !status_flags.mdpe)
    else $error("data parity flag not cleared");

  a_sse_clear: assert property (
    clk_en && reg_wr && reg_addr == `BCHR_OFS_CMD_STAT
      && reg_wdata[`BCHR_ST_SSE_BIT] && !(evt.err_msg && serr_en)
      |=> !status_flags.sse)
    else $error("system error flag not cleared");

  // a zero write leaves a set flag alone
  a_w1c_keep: assert property (
    clk_en && reg_wr && reg_addr == `BCHR_OFS_CMD_STAT
      && !reg_wdata[`BCHR_ST_DPE_BIT] && status_flags.dpe |=> status_flags.dpe)
    else $error("detected parity dropped by zero write");

  // event and clear in one cycle: the event wins
  a_set_wins: assert property (
    clk_en && evt.poison && reg_wr && reg_addr == `BCHR_OFS_CMD_STAT
      |=> status_flags.dpe)
    else $error("clear beat a same-cycle event");

  // error message with enable raises the flag
  a_sse_set: assert property (
    clk_en && evt.err_msg && serr_en |=> status_flags.sse)
    else $error("system error not set");

  // enables follow the command half of the write
  a_perr_write: assert property (
    clk_en && reg_wr && reg_addr == `BCHR_OFS_CMD_STAT
      |=> perr_resp_en == $past(reg_wdata[`BCHR_CMD_PERR_BIT]))
    else $error("parity response enable not written");

  a_serr_write: assert property (
    clk_en && reg_wr && reg_addr == `BCHR_OFS_CMD_STAT
      |=> serr_en == $past(reg_wdata[`BCHR_CMD_SERR_BIT]))
    else $error("system error enable not written");

  // bus numbers move only on their own write
  a_bus_keep: assert property (
    !(clk_en && reg_wr && reg_addr == `BCHR_OFS_BUS) |=> $stable(bus_num))
    else $error("bus numbers changed without write");

  // readback of the bus word
  a_bus_read: assert property (
    clk_en && reg_rd && reg_addr == `BCHR_OFS_BUS
      |=> reg_rdata == {8'h00, $past(bus_num)})
    else $error("bus number word wrong");

  a_sec_lat_zero: assert property (
    clk_en && reg_rd && reg_addr == `BCHR_OFS_BUS |=> reg_rdata[31:24] == 8'h00)
    else $error("secondary latency timer not zero");

  // readback of the cache and header word
  a_hdr_read: assert property (
    clk_en && reg_rd && reg_addr == `BCHR_OFS_CACHE_HDR
      |=> reg_rdata[31:8] == 24'h000100)
    else $error("header type or latency byte wrong");

  a_cache_read: assert property (
    clk_en && reg_rd && reg_addr == `BCHR_OFS_CACHE_HDR
      |=> reg_rdata[7:0] == $past(st_q.cache_line))
    else $error("cache line byte wrong");

  // unmapped words read as zero
  a_unmapped_zero: assert property (
    clk_en && reg_rd && reg_addr != `BCHR_OFS_CMD_STAT
      && reg_addr != `BCHR_OFS_REV_CLASS && reg_addr != `BCHR_OFS_CACHE_HDR
      && reg_addr != `BCHR_OFS_BUS |=> reg_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  // first edge after a reset release
  a_flags_reset: assert property (
    $rose(rst_b) |-> status_flags == 6'h00)
    else $error("status flags not clear after reset");

  a_bus_reset: assert property (
    $rose(rst_b) |-> bus_num == 24'h000000 && st_q.cache_line == 8'h00)
    else $error("bus or cache byte not zero after reset");

  a_ctrl_reset: assert property (
    $rose(rst_b) |-> !serr_en && !perr_resp_en)
    else $error("enables not zero after reset");

  c_parity_seen: cover property (
    clk_en && evt.parity && perr_resp_en ##1 status_flags.mdpe);
  c_clear_race: cover property (
    clk_en && reg_wr && reg_addr == `BCHR_OFS_CMD_STAT
      && reg_wdata[`BCHR_ST_DPE_BIT] && evt.poison);
  c_bus_read: cover property (
    clk_en && reg_rd && reg_addr == `BCHR_OFS_BUS
      && bus_num != 24'h000000);
  c_wr_then_rd: cover property (
    clk_en && reg_wr && reg_addr == `BCHR_OFS_CACHE_HDR
      ##1 clk_en && reg_rd && reg_addr == `BCHR_OFS_CACHE_HDR);
  c_frozen_write: cover property (
    !clk_en && reg_wr && reg_addr == `BCHR_OFS_BUS);

endmodule : bchr_regs
`default_nettype wire

// ===== verification/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import bchr_pkg::*;
  // revision code, value arbitrary
  localparam logic [7:0] REV = 8'h5a;
  // clock, reset, enable
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic clk_en = 1'b1;
  // register port
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  // events and controls
  bchr_evt_t evt = '0;
  logic perr_resp_en;
  logic serr_en;
  bchr_bus_t bus_num;
  bchr_flags_t status_flags;
  // bench state
  int num_errors = 0;
  int samples_checked = 0;
  logic [31:0] exp_q[$];
  logic rd_q = 1'b0;
  logic [31:0] seed = 32'd35918;
  logic [31:0] v;
  logic [5:0] exp_f;
  always #4 sys_clk = ~sys_clk;
  bchr_regs #(.REV_ID(REV)) DUT (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .evt(evt), .perr_resp_en(perr_resp_en), .serr_en(serr_en),
    .bus_num(bus_num), .status_flags(status_flags));
  // xorshift source for register data
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one-cycle write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // one-cycle read, expectation queued
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask
  // write then read back with no gap between the strobes
  task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask
  // event and clearing status write in one cycle
  task automatic ev_clr(input bchr_evt_t e, input logic [31:0] d, input logic [5:0] ef);
    @(posedge sys_clk);
    evt <= e;
    reg_addr <= 8'h04;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    evt <= '0;
    reg_wr <= 1'b0;
    #1;
    check(32'(status_flags), 32'(ef));
  endtask
  // one-cycle event pulse, flags checked once settled
  task automatic ev(input bchr_evt_t e, input logic [5:0] ef);
    @(posedge sys_clk);
    evt <= e;
    @(posedge sys_clk);
    evt <= '0;
    #1;
    check(32'(status_flags), 32'(ef));
  endtask
  // read data stands only in the cycle after the strobe
  always @(posedge sys_clk) begin
    rd_q <= reg_rd & clk_en;
    if (rd_q) begin
      if (exp_q.size() == 0) check(reg_rdata, 32'hdead_beef);
      else check(reg_rdata, exp_q.pop_front());
    end
  end
  // verdict, single exit point
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    stop_test();
  end
  // main sequence
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    #1;
    check(32'(status_flags), 32'h0);
    rd(8'h04, 32'h0010_0000);
    rd(8'h08, {8'h06, 8'h04, 8'h00, REV});
    rd(8'h0c, 32'h0001_0000);
    rd(8'h18, 32'h0);
    rd(8'h10, 32'h0);
    $display("reset values done");
    wr(8'h08, 32'hffff_ffff);
    wr(8'h10, 32'hffff_ffff);
    wr_rd(8'h0c, 32'hffff_ffff, 32'h0001_00ff);
    rd(8'h08, {8'h06, 8'h04, 8'h00, REV});
    rd(8'h10, 32'h0);
    for (int i = 0; i < 4; i++) begin
      v = xs();
      wr_rd(8'h18, v, {8'h00, v[23:0]});
      check(32'(bus_num), {8'h00, v[23:0]});
    end
    clk_en <= 1'b0;
    wr(8'h18, 32'h0);
    clk_en <= 1'b1;
    rd(8'h18, {8'h00, v[23:0]});
    $display("read-write fields done");
    ev(6'h22, 6'h00);
    wr(8'h04, 32'hffff_0140);
    #1;
    check({30'h0, perr_resp_en, serr_en}, 32'h3);
    exp_f = 6'h00;
    for (int i = 0; i < 6; i++) begin
      exp_f[5 - i] = 1'b1;
      ev(bchr_evt_t'(6'h01 << i), exp_f);
    end
    rd(8'h04, 32'hf910_0140);
    wr(8'h04, 32'h0000_0140);
    rd(8'h04, 32'hf910_0140);
    wr(8'h04, 32'hffff_0140);
    rd(8'h04, 32'h3810_0140);
    wr(8'h04, 32'h0);
    ev(6'h22, 6'h0e);
    ev_clr(6'h01, 32'h8000_0000, 6'h2e);
    $display("status flags done");
    @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    #1;
    check(32'(status_flags), 32'h0);
    check(32'(bus_num), 32'h0);
    rd(8'h0c, 32'h0001_0000);
    rd(8'h04, 32'h0010_0000);
    $display("second reset done");
    repeat (3) @(posedge sys_clk);
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
